// [hw/rfsrs_defs.vh]
// rfsrs_defs.vh: offsets, field positions, reset values and codes of the switch slave.
// assumes: included by the design files by bare name; definitions only.
`ifndef RFSRS_DEFS_VH
`define RFSRS_DEFS_VH

// register addresses (five-bit register address field)
`define RFSRS_ADDR_PATH        5'h00
`define RFSRS_ADDR_PWR         5'h1c
`define RFSRS_ADDR_PART        5'h1d
`define RFSRS_ADDR_MAKER_LO    5'h1e
`define RFSRS_ADDR_MAKER_HI    5'h1f

// reset values
`define RFSRS_PATH_RST         8'h00
`define RFSRS_PWR_RST          8'h00
`define RFSRS_USID_RST         4'hb

// power_and_load_control field positions
`define RFSRS_BIT_LOW_POWER    7
`define RFSRS_BIT_STARTUP      6
`define RFSRS_BIT_MASK_LO      3
`define RFSRS_BIT_TRIG_LO      0

// command frame fields (13-bit frame incl. parity, parity in bit 0)
`define RFSRS_CMD_SA_HI        12
`define RFSRS_CMD_SA_LO        9
`define RFSRS_CMD_SHORT        8
`define RFSRS_CMD_OP_HI        7
`define RFSRS_CMD_OP_LO        6
`define RFSRS_OP_WRITE         2'h2
`define RFSRS_OP_READ          2'h3

// frame lengths in bits without parity; the read count includes parity
`define RFSRS_CMD_BITS         4'hc
`define RFSRS_DATA_BITS        4'h8
`define RFSRS_READ_DONE        4'h9

// path-select codes
`define RFSRS_PATH_ISO         8'h00
`define RFSRS_PATH_RF1         8'h0b
`define RFSRS_PATH_RF2         8'h04
`define RFSRS_PATH_RF3         8'h0e
`define RFSRS_PATH_RF4         8'h06
`define RFSRS_PATH_RF5         8'h0a
`define RFSRS_PATH_RF6         8'h09

`endif

// [hw/rfsrs_sync.v]
// rfsrs_sync.v: two-flop synchronisers and edge pulses for the bus clock and data pins.
// assumes: pins are asynchronous to i_clk; bus clock period is many i_clk periods.
`timescale 1ns/1ns
module rfsrs_sync (
   // clock and reset
   input  wire       i_clk,
   input  wire       i_reset_n,
   // raw pins
   input  wire       i_sclk,
   input  wire       i_sdata,
   // synchronised levels and edges
   output wire       o_sclk,
   output wire       o_sdata,
   output wire       o_sclk_rise,
   output wire       o_sclk_fall,
   output wire       o_sdata_rise,
   output wire       o_sdata_fall
);

   wire [1:0] pin_in;
   wire [1:0] lvl;
   wire [1:0] rise;
   wire [1:0] fall;

   assign pin_in = {i_sdata, i_sclk};

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_pin
         reg meta_reg;
         reg sync_reg;
         reg last_reg;
         always @(posedge i_clk) begin
            if (!i_reset_n) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
               last_reg <= 1'b0;
            end else begin
               meta_reg <= pin_in[g];
               sync_reg <= meta_reg;
               last_reg <= sync_reg;
            end
         end
         // edges compare the second stage with the third
         assign lvl[g]  = sync_reg;
         assign rise[g] = sync_reg & ~last_reg;
         assign fall[g] = ~sync_reg & last_reg;
      end
   endgenerate

   assign o_sclk       = lvl[0];
   assign o_sdata      = lvl[1];
   assign o_sclk_rise  = rise[0];
   assign o_sclk_fall  = fall[0];
   assign o_sdata_rise = rise[1];
   assign o_sdata_fall = fall[1];

endmodule

// [hw/rfsrs_top.v]
// rfsrs_top.v: serial-control slave of an SP6T antenna switch on a two-wire bus.
// assumes: bus clock and data come from a bus master, asynchronous to i_clk,
// bus clock slower than i_clk / 4; data pin is shared, master parks it low.
// a bus clock stopped mid-read leaves the pin driven until it runs again.
// Function
// [RULE1] sequence start, then slave address and parity
// [RULE2] register write: op 10, data, parity, park
// [RULE3] register read: park, device drives data, parity, park
// [RULE4] path register at 0, short write loads seven bits
// [RULE5] path codes decode to isolation or ports 1-6
// [RULE6] mask bit set: writes go straight through
// [RULE7] mask bit clear: writes land in shadow
// [RULE8] trigger write copies shadow when mask clear
// [RULE9] all three triggers load the path register
// [RULE10] power bits: startup resets all, low power
// [RULE11] part number read-only at 0x1d
// [RULE12] maker code low read-only, writes ignored
// [RULE13] 0x1f upper bits reserved zero, maker high read-only
// [RULE14] slave id writable, resets to 1011
// [RULE15] act only on own id and good parity
// [RULE16] triggers read zero, load at sequence end
`timescale 1ns/1ns
`include "rfsrs_defs.vh"
module rfsrs_top #(
   parameter [7:0] PART_NUMBER = 8'h3c,   // arbitrary value
   parameter [9:0] MAKER_CODE  = 10'h2a7  // arbitrary value
) (
   // clock and reset
   input  wire       i_clk,
   input  wire       i_reset_n,
   // serial bus pins
   input  wire       i_sclk,
   input  wire       i_sdata,
   output reg        o_sdata,
   output reg        o_sdata_oe_n,
   // switch control
   output reg  [7:0] o_path_select,
   output reg        o_isolate,
   output reg  [5:0] o_port_en,
   output reg        o_low_power
);

   localparam [5:0] ST_IDLE  = 6'h01;
   localparam [5:0] ST_CMD   = 6'h02;
   localparam [5:0] ST_WDATA = 6'h04;
   localparam [5:0] ST_RPARK = 6'h08;
   localparam [5:0] ST_RDATA = 6'h10;
   localparam [5:0] ST_PARK  = 6'h20;

   wire        sclk_s;
   wire        sdata_s;
   wire        sclk_rise;
   wire        sclk_fall;
   wire        sdata_rise;
   wire        sdata_fall;

   reg  [5:0]  state_reg;
   reg  [3:0]  cnt_reg;
   reg  [12:0] shift_reg;
   reg  [4:0]  addr_reg;
   reg  [8:0]  rd_shift_reg;
   reg         ssc_arm_reg;
   reg  [7:0]  path_reg;
   reg  [7:0]  shadow_reg;
   reg  [2:0]  mask_reg;
   reg         low_power_reg;
   reg  [3:0]  usid_reg;

   reg  [7:0]  path_next;
   reg  [5:0]  port_next;
   reg         iso_next;

   wire [12:0] frame;
   wire        frame_par_ok;
   wire [9:0]  data_frame;
   wire        data_par_ok;
   wire        ssc;

   wire        cmd_for_us;
   wire        cmd_short;
   wire        cmd_write;
   wire        cmd_read;
   wire [4:0]  cmd_addr;
   wire [7:0]  rd_word;
   wire        rd_par;

   rfsrs_sync u_sync (
      .i_clk        (i_clk),
      .i_reset_n    (i_reset_n),
      .i_sclk       (i_sclk),
      .i_sdata      (i_sdata),
      .o_sclk       (sclk_s),
      .o_sdata      (sdata_s),
      .o_sclk_rise  (sclk_rise),
      .o_sclk_fall  (sclk_fall),
      .o_sdata_rise (sdata_rise),
      .o_sdata_fall (sdata_fall)
   );

   // start: data pulses high then low while the bus clock stays low
   assign ssc = sdata_fall & ~sclk_s & ssc_arm_reg & o_sdata_oe_n; // RULE1

   // frame including the bit being sampled now
   assign frame        = {shift_reg[11:0], sdata_s};
   assign frame_par_ok = ^frame;                                   // RULE15
   assign data_frame   = {shift_reg[8:0], sdata_s};
   assign data_par_ok  = ^data_frame[8:0];                         // RULE15

   // command fields; parity and slave id gate every kind of command
   assign cmd_for_us = frame_par_ok &
                       (frame[`RFSRS_CMD_SA_HI:`RFSRS_CMD_SA_LO] == usid_reg); // RULE15
   assign cmd_short  = frame[`RFSRS_CMD_SHORT];
   assign cmd_write  = ~cmd_short &
                       (frame[`RFSRS_CMD_OP_HI:`RFSRS_CMD_OP_LO] == `RFSRS_OP_WRITE);
   assign cmd_read   = ~cmd_short &
                       (frame[`RFSRS_CMD_OP_HI:`RFSRS_CMD_OP_LO] == `RFSRS_OP_READ);
   assign cmd_addr   = frame[5:1];

   // read data mux; trigger bits and reserved bits return zero
   function [7:0] rd_val;
      input [4:0] a;
      begin
         if (a == `RFSRS_ADDR_PATH)
            rd_val = path_reg;
         else if (a == `RFSRS_ADDR_PWR)
            rd_val = {low_power_reg, 1'b0, mask_reg, 3'b000};      // RULE16
         else if (a == `RFSRS_ADDR_PART)
            rd_val = PART_NUMBER;                                  // RULE11
         else if (a == `RFSRS_ADDR_MAKER_LO)
            rd_val = MAKER_CODE[7:0];                              // RULE12
         else if (a == `RFSRS_ADDR_MAKER_HI)
            rd_val = {2'b00, MAKER_CODE[9:8], usid_reg};           // RULE13
         else
            rd_val = 8'h00;
      end
   endfunction

   // word and parity loaded into the read shifter
   assign rd_word = rd_val(cmd_addr);
   assign rd_par  = ~^rd_word;                                     // RULE3

   // path-select decode to port enables
   always @* begin
      port_next = 6'h00;
      iso_next  = 1'b0;
      case (path_next)                                             // RULE5
         `RFSRS_PATH_RF1: port_next = 6'h01;
         `RFSRS_PATH_RF2: port_next = 6'h02;
         `RFSRS_PATH_RF3: port_next = 6'h04;
         `RFSRS_PATH_RF4: port_next = 6'h08;
         `RFSRS_PATH_RF5: port_next = 6'h10;
         `RFSRS_PATH_RF6: port_next = 6'h20;
         default:         iso_next  = 1'b1;
      endcase
   end

   // a path value other than the listed codes isolates all ports too
   always @* begin
      path_next = path_reg;
   end

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         state_reg     <= ST_IDLE;
         cnt_reg       <= 4'h0;
         shift_reg     <= 13'h0000;
         addr_reg      <= 5'h00;
         rd_shift_reg  <= 9'h000;
         ssc_arm_reg   <= 1'b0;
         path_reg      <= `RFSRS_PATH_RST;                         // RULE4
         shadow_reg    <= `RFSRS_PATH_RST;
         mask_reg      <= 3'b000;
         low_power_reg <= 1'b0;
         usid_reg      <= `RFSRS_USID_RST;                         // RULE14
         o_sdata       <= 1'b0;
         o_sdata_oe_n  <= 1'b1;
         o_path_select <= `RFSRS_PATH_RST;
         o_isolate     <= 1'b1;
         o_port_en     <= 6'h00;
         o_low_power   <= 1'b0;
      end else begin
         o_path_select <= path_next;
         o_isolate     <= iso_next;
         o_port_en     <= port_next;
         o_low_power   <= low_power_reg;

         // data moving with a clock rise must never arm a start
         if (sclk_rise)
            ssc_arm_reg <= 1'b0;
         else if (sdata_rise & ~sclk_s)
            ssc_arm_reg <= 1'b1;

         if (ssc) begin
            state_reg   <= ST_CMD;
            cnt_reg     <= 4'h0;
            ssc_arm_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_CMD: begin
                  if (sclk_fall) begin
                     shift_reg <= frame;
                     cnt_reg   <= cnt_reg + 4'h1;
                     if (cnt_reg == `RFSRS_CMD_BITS) begin
                        cnt_reg   <= 4'h0;
                        addr_reg  <= cmd_addr;
                        state_reg <= ST_IDLE;
                        if (cmd_for_us) begin                       // RULE15
                           if (cmd_short) begin
                              // short write of path register, bit 7 cleared
                              reg_write(`RFSRS_ADDR_PATH, {1'b0, frame[7:1]}); // RULE4
                           end else if (cmd_write) begin
                              state_reg <= ST_WDATA;                // RULE2
                           end else if (cmd_read) begin
                              state_reg    <= ST_RPARK;             // RULE3
                              rd_shift_reg <= {rd_word, rd_par};
                           end
                        end
                     end
                  end
               end
               ST_WDATA: begin
                  if (sclk_fall) begin
                     shift_reg <= {3'b000, data_frame};
                     cnt_reg   <= cnt_reg + 4'h1;
                     if (cnt_reg == `RFSRS_DATA_BITS) begin
                        cnt_reg   <= 4'h0;
                        state_reg <= ST_IDLE;
                        if (data_par_ok)                            // RULE2
                           reg_write(addr_reg, data_frame[8:1]);
                     end
                  end
               end
               ST_RPARK: begin
                  // master parks the line for one bus clock before we drive
                  if (sclk_fall)
                     state_reg <= ST_RDATA;                        // RULE3
               end
               ST_RDATA: begin
                  if (sclk_rise) begin
                     o_sdata_oe_n <= 1'b0;
                     cnt_reg      <= cnt_reg + 4'h1;
                     if (cnt_reg == `RFSRS_READ_DONE) begin
                        // drive low for the closing park, release on next fall
                        o_sdata   <= 1'b0;
                        cnt_reg   <= 4'h0;
                        state_reg <= ST_PARK;                      // RULE3
                     end else begin
                        o_sdata      <= rd_shift_reg[8];
                        rd_shift_reg <= {rd_shift_reg[7:0], 1'b0};
                     end
                  end
               end
               ST_PARK: begin
                  if (sclk_fall) begin
                     o_sdata_oe_n <= 1'b1;
                     o_sdata      <= 1'b0;
                     state_reg    <= ST_IDLE;
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // register write effects; only called from the clocked process
   task reg_write;
      input [4:0] a;
      input [7:0] d;
      reg   [2:0] fire;
      begin
         fire = 3'b000;
         if (a == `RFSRS_ADDR_PATH) begin
            shadow_reg <= d;                                       // RULE7
            if (|mask_reg)
               path_reg <= d;                                      // RULE6
         end else if (a == `RFSRS_ADDR_PWR) begin
            if (d[`RFSRS_BIT_STARTUP]) begin
               // startup: every register back to its default
               path_reg      <= `RFSRS_PATH_RST;                   // RULE10
               shadow_reg    <= `RFSRS_PATH_RST;
               mask_reg      <= 3'b000;
               low_power_reg <= 1'b0;
               usid_reg      <= `RFSRS_USID_RST;
            end else begin
               low_power_reg <= d[`RFSRS_BIT_LOW_POWER];           // RULE10
               mask_reg      <= d[`RFSRS_BIT_MASK_LO+2:`RFSRS_BIT_MASK_LO];
               // trigger gated by the mask written in the same frame
               fire = d[`RFSRS_BIT_TRIG_LO+2:`RFSRS_BIT_TRIG_LO] &
                      ~d[`RFSRS_BIT_MASK_LO+2:`RFSRS_BIT_MASK_LO]; // RULE8
               if (|fire)
                  path_reg <= shadow_reg;                          // RULE9 RULE16
            end
         end else if (a == `RFSRS_ADDR_MAKER_HI) begin
            usid_reg <= d[3:0];                                    // RULE14 RULE13
         end
         // part number and maker code low take the write and keep their value
      end
   endtask

endmodule

// [sim/rfsrs_checker.sv]
// rfsrs_checker.sv: port-level checks of the switch slave.
// assumes: one clock domain, synchronous active-low reset, 80 ns bus clock.
`timescale 1ns/1ns
module rfsrs_checker (
   // clock and reset
   input logic       i_clk,
   input logic       i_reset_n,
   // bus pins
   input logic       i_sclk,
   input logic       i_sdata,
   input logic       o_sdata,
   input logic       o_sdata_oe_n,
   // switch control
   input logic [7:0] o_path_select,
   input logic       o_isolate,
   input logic [5:0] o_port_en,
   input logic       o_low_power
);
   logic [7:0] drv_cnt;
   always @(posedge i_clk) begin
      if (!i_reset_n || o_sdata_oe_n) drv_cnt <= 8'h00;
      else if (drv_cnt != 8'hff) drv_cnt <= drv_cnt + 8'h01;
   end
   function automatic logic [5:0] ports(input logic [7:0] p);
      case (p)
         8'h0b: ports = 6'h01;
         8'h04: ports = 6'h02;
         8'h0e: ports = 6'h04;
         8'h06: ports = 6'h08;
         8'h0a: ports = 6'h10;
         8'h09: ports = 6'h20;
         default: ports = 6'h00;
      endcase
   endfunction
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   sequence drv_end;
      !o_sdata_oe_n ##1 o_sdata_oe_n;
   endsequence
   sequence path_settled;
      $stable(o_path_select) [*2];
   endsequence
   reset_vals_a: assert property ($rose(i_reset_n) |-> o_path_select == 8'h00
      && o_port_en == 6'h00 && o_isolate && !o_low_power && o_sdata_oe_n) else $error("reset values");
   port_decode_a: assert property (path_settled |-> o_port_en == ports(o_path_select))
      else $error("port decode wrong");
   isolate_match_a: assert property (path_settled |-> o_isolate == (ports(o_path_select) == 6'h00))
      else $error("isolate wrong");
   drive_start_a: assert property ($fell(o_sdata_oe_n) |-> i_sclk)
      else $error("drive began off clock high");
   bit_hold_a: assert property (!o_sdata_oe_n && $changed(o_sdata) |-> i_sclk)
      else $error("read bit moved off clock high");
   park_low_a: assert property (drv_end |-> !$past(o_sdata))
      else $error("final park not low");
   drive_len_a: assert property (drv_end |-> $past(drv_cnt) inside {[8'd68:8'd84]})
      else $error("drive window length wrong");
   idle_release_a: assert property (!i_sclk [*8] |-> o_sdata_oe_n)
      else $error("driving while bus idle");
   path_quiet_a: assert property ($changed(o_path_select) |-> o_sdata_oe_n)
      else $error("path changed during read");
   power_quiet_a: assert property ($changed(o_low_power) |-> o_sdata_oe_n)
      else $error("power changed during read");
endmodule

bind rfsrs_top rfsrs_checker chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(i_sclk),
   .i_sdata(i_sdata), .o_sdata(o_sdata), .o_sdata_oe_n(o_sdata_oe_n),
   .o_path_select(o_path_select), .o_isolate(o_isolate), .o_port_en(o_port_en),
   .o_low_power(o_low_power));

// [sim/rfsrs_master_model.sv]
// rfsrs_master_model.sv: bus master model making bus clock and data.
// assumes: system clock 10 ns; bus clock 80 ns, stands low between frames.
`timescale 1ns/1ns
module rfsrs_master_model (
   // clock
   input  logic i_clk,
   // bus pins
   input  logic i_sdata,
   output logic o_sclk,
   output logic o_sdata,
   output logic o_release
);
   initial begin
      o_sclk = 1'b0;
      o_sdata = 1'b0;
      o_release = 1'b0;
   end
   task automatic half();
      repeat (4) @(negedge i_clk);
   endtask
   task automatic bit_out(input logic b);
      o_sclk = 1'b1;
      o_sdata = b;
      half();
      o_sclk = 1'b0;
      half();
   endtask
   // c is command bits 7:0; bad[0] flips the command parity, bad[1] the data parity
   task automatic xfer(input logic [3:0] sa, input logic [7:0] c, input logic [7:0] d,
                       input logic [1:0] bad, output logic [8:0] q);
      logic [11:0] cw;
      q = 9'h000;
      cw = {sa, c};
      @(negedge i_clk);
      o_sdata = 1'b1;
      half();
      o_sdata = 1'b0;
      half();
      for (int i = 11; i >= 0; i--) bit_out(cw[i]);
      bit_out(~^cw ^ bad[0]);
      if (c[7:5] == 3'b011) begin
         bit_out(1'b0);
         o_release = 1'b1;
         for (int i = 0; i < 10; i++) begin
            o_sclk = 1'b1;
            half();
            if (i < 9) q = {q[7:0], i_sdata};
            o_sclk = 1'b0;
            half();
         end
         o_release = 1'b0;
      end else begin
         if (!c[7]) begin
            for (int i = 7; i >= 0; i--) bit_out(d[i]);
            bit_out(~^d ^ bad[1]);
         end
         bit_out(1'b0);
      end
   endtask
endmodule

// [sim/rfsrs_top_bench.sv]
// rfsrs_top_bench.sv: self-checking bench of the switch slave.
// assumes: master model drives the pins; inputs change on falling clock edges.
`timescale 1ns/1ns
module rfsrs_top_bench;
   localparam logic [7:0] PART = 8'h5a;   // arbitrary value
   localparam logic [9:0] MAKER = 10'h1c3; // arbitrary value
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       sclk, m_sdata, m_rel, s_sdata, s_oe_n, isolate, low_power;
   wire        sdata_w = !s_oe_n ? s_sdata : (m_rel ? ~m_sdata : m_sdata);
   logic [7:0] path;
   logic [5:0] port_en;
   logic [3:0] sa = 4'hb;
   logic [8:0] q;
   logic [7:0] codes [7] = '{8'h00, 8'h0b, 8'h04, 8'h0e, 8'h06, 8'h0a, 8'h09};
   int         errors = 0;
   int         n_compared = 0;
   int         cyc = 0;
   always #5 clk = ~clk;
   rfsrs_master_model m (.i_clk(clk), .i_sdata(sdata_w), .o_sclk(sclk), .o_sdata(m_sdata),
      .o_release(m_rel));
   rfsrs_top #(.PART_NUMBER(PART), .MAKER_CODE(MAKER)) dut (.i_clk(clk), .i_reset_n(reset_n),
      .i_sclk(sclk), .i_sdata(sdata_w), .o_sdata(s_sdata), .o_sdata_oe_n(s_oe_n),
      .o_path_select(path), .o_isolate(isolate), .o_port_en(port_en), .o_low_power(low_power));
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end
   task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] bad = 2'b00);
      m.xfer(sa, {3'b010, a}, d, bad, q);
   endtask
   task automatic sw(input logic [7:0] d);
      m.xfer(sa, {1'b1, d[6:0]}, 8'h00, 2'b00, q);
   endtask
   task automatic rd(input string n, input logic [4:0] a, input logic [7:0] e);
      m.xfer(sa, {3'b011, a}, 8'h00, 2'b00, q);
      chk(n, {e, ~^e}, q);
   endtask
   // i indexes codes; entry 0 is isolation
   task automatic outs(input int i);
      logic [5:0] pe;
      pe = (i == 0) ? 6'h00 : 6'h01 << (i - 1);
      chk("path", {1'b0, codes[i]}, {1'b0, path});
      chk("ports", {3'h0, pe}, {3'h0, port_en});
      chk("isolate", {8'h00, pe == 6'h00}, {8'h00, isolate});
   endtask
   initial begin
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      repeat (5) @(negedge clk);
      outs(0);
      chk("low_power", 9'h000, {8'h00, low_power});
      rd("pwr", 5'h1c, 8'h00);
      rd("part", 5'h1d, PART);
      rd("maker_lo", 5'h1e, MAKER[7:0]);
      rd("maker_hi", 5'h1f, {2'b00, MAKER[9:8], 4'hb});
      $display("test reset done");
      for (int t = 0; t < 3; t++) begin
         wr(5'h00, codes[t + 1]);
         outs(t);
         wr(5'h1c, 8'h01 << t);
         outs(t + 1);
      end
      wr(5'h00, codes[4]);
      wr(5'h1c, 8'h00);
      outs(3);
      rd("trig", 5'h1c, 8'h00);
      $display("test shadow done");
      wr(5'h1c, 8'h38);
      rd("masks", 5'h1c, 8'h38);
      for (int i = 0; i < 7; i++) begin
         wr(5'h00, codes[i]);
         outs(i);
      end
      sw(8'h0e);
      outs(3);
      sw(8'hff);
      chk("short", 9'h0ff, {path, isolate});
      $display("test direct done");
      sw(8'h0b);
      wr(5'h00, codes[2], 2'b01);
      outs(1);
      wr(5'h00, codes[2], 2'b10);
      outs(1);
      wr(5'h1d, 8'hff);
      wr(5'h1e, 8'hff);
      wr(5'h1f, 8'hf5);
      sa = 4'h5;
      rd("part", 5'h1d, PART);
      rd("maker_lo", 5'h1e, MAKER[7:0]);
      rd("maker_hi", 5'h1f, {2'b00, MAKER[9:8], 4'h5});
      sa = 4'hb;
      wr(5'h00, codes[2]);
      outs(1);
      $display("test id done");
      sa = 4'h5;
      wr(5'h1c, 8'hb8);
      chk("low_power", 9'h001, {8'h00, low_power});
      rd("pwr", 5'h1c, 8'hb8);
      wr(5'h1c, 8'h40);
      sa = 4'hb;
      chk("low_power", 9'h000, {8'h00, low_power});
      outs(0);
      rd("pwr", 5'h1c, 8'h00);
      rd("maker_hi", 5'h1f, {2'b00, MAKER[9:8], 4'hb});
      wr(5'h00, codes[5]);
      outs(0);
      $display("test startup done");
      end_sim();
   end
endmodule
